/* ddcb_bank.sv */
// Purpose: Down-converter preset select, channel binding and reference divisor bank
// Assumes: Avalon-MM slave with byte address; inputs synchronous to clk_sys_i
// Notes: Answers every access one cycle after it is presented
//
// Local design decision: the Avalon-MM slave port.
`timescale 1ns/1ps
`include "ddcb_cfg.svh"

module ddcb_bank import ddcb_pkg::*; #(
   parameter int DW = 12
) (
   input wire logic clk_sys_i,
   input wire logic srst_i,
   input wire logic [`DDCB_ADDR_W-1:0] avs_address_i,
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic [3:0] avs_byteenable_i,
   input wire logic [31:0] avs_writedata_i,
   output logic [31:0] avs_readdata_o,
   output logic avs_waitrequest_o,
   input wire logic [1:0] preset_pins_a_i,
   input wire logic [1:0] preset_pins_b_i,
   input wire logic [DW-1:0] conv_a_data_i,
   input wire logic [DW-1:0] conv_b_data_i,
   output logic [1:0] active_preset_a_o,
   output logic [1:0] active_preset_b_o,
   output logic [15:0] ref_divisor_o,
   output logic ref_divisor_en_o,
   output logic dig_chan_a_pd_o,
   output logic dig_chan_b_pd_o,
   output logic [DW-1:0] dig_chan_a_data_o,
   output logic [DW-1:0] dig_chan_b_data_o
);

   ddcb_state_e state;
   ddcb_state_e next_state;
   logic [7:0] mode_q;
   logic [7:0] preset_select;
   logic [7:0] channel_binding;
   logic [15:0] ref_divisor;
   logic [7:0] ctrl_q;

   // Address decode
   function automatic logic hit(input logic [`DDCB_ADDR_W-1:0] a, input logic [`DDCB_IDX_W-1:0] i);
      hit = (a[`DDCB_ADDR_W-1:2] == i);
   endfunction

   // Preset choice for one down-converter
   function automatic ddcb_preset_t pick(input ddcb_mode_e m, input ddcb_preset_t by_reg,
                                         input ddcb_preset_t by_pin, input ddcb_preset_t pin_a);
      case (m)
         DDCB_MODE_PINS_EACH: pick = by_pin;
         DDCB_MODE_PINS_A: pick = pin_a;
         default: pick = by_reg;
      endcase
   endfunction

   wire req = avs_read_i | avs_write_i;
   wire wr_take = avs_write_i && (state == DDCB_ST_ACK);
   wire hit_mode = hit(avs_address_i, `DDCB_IDX_MODE);
   wire hit_sel = hit(avs_address_i, `DDCB_IDX_PRESET_SELECT);
   wire hit_bind = hit(avs_address_i, `DDCB_IDX_CHANNEL_BINDING);
   wire hit_div = hit(avs_address_i, `DDCB_IDX_REF_DIVISOR);
   wire hit_ctrl = hit(avs_address_i, `DDCB_IDX_CTRL);
   wire hit_stat = hit(avs_address_i, `DDCB_IDX_STATUS);

   wire single_mode = ctrl_q[`DDCB_CTRL_SINGLE_BIT];
   wire conv_a_pd = ctrl_q[`DDCB_CTRL_PD_A_BIT];
   wire conv_b_pd = ctrl_q[`DDCB_CTRL_PD_B_BIT];
   wire bind_a = channel_binding[`DDCB_BIND_A_BIT];
   wire bind_b = channel_binding[`DDCB_BIND_B_BIT];
   wire ddcb_mode_e src_mode = ddcb_mode_e'(mode_q[`DDCB_MODE_MSB:`DDCB_MODE_LSB]);
   wire ddcb_preset_t sel_a = preset_select[`DDCB_SEL_A_MSB:`DDCB_SEL_A_LSB];
   wire ddcb_preset_t sel_b = preset_select[`DDCB_SEL_B_MSB:`DDCB_SEL_B_LSB];

   // Preset selection per source mode; single channel follows the A path
   wire ddcb_preset_t next_preset_a = pick(src_mode, sel_a, preset_pins_a_i,
                                          preset_pins_a_i);
   wire ddcb_preset_t pick_b = pick(src_mode, sel_b, preset_pins_b_i, preset_pins_a_i);
   wire ddcb_preset_t next_preset_b = single_mode ? next_preset_a : pick_b;

   // A digital channel follows the power state of the converter it is bound to
   wire next_pd_a = bind_a ? conv_b_pd : conv_a_pd;
   wire next_pd_b = bind_b ? conv_b_pd : conv_a_pd;
   wire [DW-1:0] next_data_a = bind_a ? conv_b_data_i : conv_a_data_i;
   wire [DW-1:0] next_data_b = bind_b ? conv_b_data_i : conv_a_data_i;

   wire [31:0] status_word = {26'h0, next_pd_b, next_pd_a, active_preset_b_o, active_preset_a_o};
   wire [31:0] next_rdata = hit_mode ? {24'h0, mode_q} :
                            hit_sel ? {24'h0, preset_select} :
                            hit_bind ? {24'h0, channel_binding} :
                            hit_div ? {16'h0, ref_divisor} :
                            hit_ctrl ? {24'h0, ctrl_q} :
                            hit_stat ? status_word : 32'h0;

   ddcb_field_reg #(.W(8), .RST(`DDCB_RST_MODE)) u_mode (
      .clk_sys_i(clk_sys_i),
      .srst_i(srst_i),
      .we_i(wr_take && hit_mode),
      .be_i(avs_byteenable_i[0]),
      .wdata_i(avs_writedata_i[7:0]),
      .q_o(mode_q)
   );

   ddcb_field_reg #(.W(8), .RST(`DDCB_RST_PRESET_SELECT)) u_sel (
      .clk_sys_i(clk_sys_i),
      .srst_i(srst_i),
      .we_i(wr_take && hit_sel),
      .be_i(avs_byteenable_i[0]),
      .wdata_i(avs_writedata_i[7:0]),
      .q_o(preset_select)
   );

   ddcb_field_reg #(.W(8), .RST(`DDCB_RST_CHANNEL_BINDING)) u_bind (
      .clk_sys_i(clk_sys_i),
      .srst_i(srst_i),
      .we_i(wr_take && hit_bind),
      .be_i(avs_byteenable_i[0]),
      .wdata_i(avs_writedata_i[7:0]),
      .q_o(channel_binding)
   );

   ddcb_field_reg #(.W(16), .RST(`DDCB_RST_REF_DIVISOR)) u_div (
      .clk_sys_i(clk_sys_i),
      .srst_i(srst_i),
      .we_i(wr_take && hit_div),
      .be_i(avs_byteenable_i[1:0]),
      .wdata_i(avs_writedata_i[15:0]),
      .q_o(ref_divisor)
   );

   ddcb_field_reg #(.W(8), .RST(`DDCB_RST_CTRL)) u_ctrl (
      .clk_sys_i(clk_sys_i),
      .srst_i(srst_i),
      .we_i(wr_take && hit_ctrl),
      .be_i(avs_byteenable_i[0]),
      .wdata_i(avs_writedata_i[7:0]),
      .q_o(ctrl_q)
   );

   // One wait cycle, then the answer for one cycle
   always_comb begin
      case (state)
         DDCB_ST_IDLE: next_state = req ? DDCB_ST_ACK : DDCB_ST_IDLE;
         DDCB_ST_ACK: next_state = DDCB_ST_IDLE;
         default: next_state = DDCB_ST_IDLE;
      endcase
   end

   assign avs_waitrequest_o = req && (state != DDCB_ST_ACK);

   always_ff @(posedge clk_sys_i) begin
      if (srst_i) begin
         state <= DDCB_ST_IDLE;
      end else begin
         state <= next_state;
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (srst_i) begin
         avs_readdata_o <= 32'h0;
      end else if (avs_read_i && state == DDCB_ST_IDLE) begin
         avs_readdata_o <= next_rdata;
      end
   end

   // One divisor for all presets; zero turns it off
   always_ff @(posedge clk_sys_i) begin
      if (srst_i) begin
         ref_divisor_o <= `DDCB_RST_REF_DIVISOR;
         ref_divisor_en_o <= 1'b0;
      end else begin
         ref_divisor_o <= ref_divisor;
         ref_divisor_en_o <= (ref_divisor != `DDCB_REF_DIV_OFF);
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (srst_i) begin
         active_preset_a_o <= 2'h0;
         active_preset_b_o <= 2'h0;
         dig_chan_a_pd_o <= 1'b0;
         dig_chan_b_pd_o <= 1'b0;
      end else begin
         active_preset_a_o <= next_preset_a;
         active_preset_b_o <= next_preset_b;
         dig_chan_a_pd_o <= next_pd_a;
         dig_chan_b_pd_o <= next_pd_b;
      end
   end

   // Powered-down channels output zero
   always_ff @(posedge clk_sys_i) begin
      if (srst_i) begin
         dig_chan_a_data_o <= '0;
         dig_chan_b_data_o <= '0;
      end else begin
         dig_chan_a_data_o <= next_pd_a ? '0 : next_data_a;
         dig_chan_b_data_o <= next_pd_b ? '0 : next_data_b;
      end
   end

   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (srst_i);

   sequence s_read_wait;
      avs_read_i && avs_waitrequest_o;
   endsequence
   sequence s_read_done;
      avs_read_i && !avs_waitrequest_o;
   endsequence
   sequence s_write_wait;
      avs_write_i && avs_waitrequest_o;
   endsequence
   sequence s_write_done;
      avs_write_i && !avs_waitrequest_o;
   endsequence

   AST_MODE_PINS_EACH: assert property (
      src_mode == DDCB_MODE_PINS_EACH && !single_mode |=>
         active_preset_b_o == $past(preset_pins_b_i))
      else $error("pin mode did not route pins B");
   AST_SEL_B_REG: assert property (
      src_mode == DDCB_MODE_REGISTER && !single_mode |=>
         active_preset_b_o == $past(sel_b))
      else $error("channel B preset not from select field");
   AST_SINGLE_B: assert property (
      single_mode |=> active_preset_b_o == active_preset_a_o)
      else $error("single mode did not ignore channel B select");
   AST_SEL_A_REG: assert property (
      src_mode == DDCB_MODE_REGISTER ##1 src_mode == DDCB_MODE_REGISTER
         |-> active_preset_a_o == $past(sel_a))
      else $error("channel A preset not from select field");
   AST_SINGLE_A: assert property (
      single_mode && src_mode == DDCB_MODE_REGISTER |=>
         active_preset_a_o == $past(sel_a))
      else $error("single channel preset wrong");
   AST_BIND_B: assert property (
      !bind_b && !conv_a_pd |=> dig_chan_b_data_o == $past(conv_a_data_i))
      else $error("channel B binding data wrong");
   AST_BIND_A: assert property (
      bind_a && !conv_b_pd |=> dig_chan_a_data_o == $past(conv_b_data_i))
      else $error("channel A binding data wrong");
   AST_PD_FOLLOW: assert property (
      $rose(conv_b_pd) && bind_a |=> dig_chan_a_pd_o ##1 dig_chan_a_pd_o || !conv_b_pd)
      else $error("bound channel not powered down");
   AST_DIV_OFF: assert property (
      ref_divisor == `DDCB_REF_DIV_OFF |=> !ref_divisor_en_o)
      else $error("divisor enabled at zero");
   AST_DIV_SHARED: assert property (
      $changed(preset_select) |=> ref_divisor_o == $past(ref_divisor))
      else $error("divisor changed with preset");
   AST_READ_ANSWER: assert property (
      s_read_wait ##1 avs_read_i |-> s_read_done)
      else $error("read not answered after one wait cycle");
   AST_MODE_PINS_A: assert property (
      src_mode == DDCB_MODE_PINS_A && !single_mode |=>
         active_preset_b_o == $past(preset_pins_a_i))
      else $error("shared pin mode did not route pins A to B");
   AST_BIND_B_OWN: assert property (
      bind_b && !conv_b_pd |=> dig_chan_b_data_o == $past(conv_b_data_i))
      else $error("channel B default binding data wrong");
   AST_BIND_A_OWN: assert property (
      !bind_a && !conv_a_pd |=> dig_chan_a_data_o == $past(conv_a_data_i))
      else $error("channel A default binding data wrong");
   AST_PD_A_BOUND: assert property (
      !bind_a |=> dig_chan_a_pd_o == $past(conv_a_pd))
      else $error("channel A power-down not from converter A");
   AST_PD_B_BOUND: assert property (
      bind_b |=> dig_chan_b_pd_o == $past(conv_b_pd))
      else $error("channel B power-down not from converter B");
   AST_PD_A_QUIET: assert property (
      dig_chan_a_pd_o |-> dig_chan_a_data_o == '0)
      else $error("powered-down channel A still carries data");
   AST_PD_B_QUIET: assert property (
      dig_chan_b_pd_o |-> dig_chan_b_data_o == '0)
      else $error("powered-down channel B still carries data");
   AST_DIV_ON: assert property (
      ref_divisor != `DDCB_REF_DIV_OFF |=>
         ref_divisor_en_o && ref_divisor_o == $past(ref_divisor))
      else $error("nonzero divisor not enabled");
   // Bus handshake: one wait state, and a write lands at its answer edge
   AST_WRITE_ANSWER: assert property (
      s_write_wait ##1 avs_write_i |-> s_write_done)
      else $error("write not answered after one wait cycle");
   AST_SEL_WRITE: assert property (
      s_write_done ##0 (hit_sel && avs_byteenable_i[0]) |=>
         preset_select == $past(avs_writedata_i[7:0]))
      else $error("preset select write did not land");

endmodule

/* ddcb_cfg.svh */
// Purpose: Addresses, reset values and field positions of the preset and binding bank
// Assumes: Register index times four is the Avalon byte address
// Notes: Definitions only
`ifndef DDCB_CFG_SVH
`define DDCB_CFG_SVH

`define DDCB_IDX_MODE 10'h214
`define DDCB_IDX_PRESET_SELECT 10'h215
`define DDCB_IDX_CHANNEL_BINDING 10'h216
`define DDCB_IDX_REF_DIVISOR 10'h217
`define DDCB_IDX_CTRL 10'h2f0
`define DDCB_IDX_STATUS 10'h2f1

`define DDCB_RST_MODE 8'h00
`define DDCB_RST_PRESET_SELECT 8'h00
`define DDCB_RST_CHANNEL_BINDING 8'h02
`define DDCB_RST_REF_DIVISOR 16'h0000
`define DDCB_RST_CTRL 8'h00

`define DDCB_MODE_MSB 1
`define DDCB_MODE_LSB 0
`define DDCB_SEL_A_MSB 1
`define DDCB_SEL_A_LSB 0
`define DDCB_SEL_B_MSB 3
`define DDCB_SEL_B_LSB 2
`define DDCB_BIND_A_BIT 0
`define DDCB_BIND_B_BIT 1
`define DDCB_CTRL_SINGLE_BIT 0
`define DDCB_CTRL_PD_A_BIT 1
`define DDCB_CTRL_PD_B_BIT 2

`define DDCB_ADDR_W 12
`define DDCB_IDX_W 10
`define DDCB_REF_DIV_OFF 16'h0000

`endif

/* ddcb_pkg.sv */
// Purpose: Types shared by the preset and binding bank
// Assumes: Used with ddcb_cfg.svh
// Notes: None
package ddcb_pkg;

   typedef enum logic [1:0] {
      DDCB_ST_IDLE = 2'b01,
      DDCB_ST_ACK = 2'b10
   } ddcb_state_e;

   typedef enum logic [1:0] {
      DDCB_MODE_REGISTER = 2'b00,
      DDCB_MODE_PINS_EACH = 2'b01,
      DDCB_MODE_PINS_A = 2'b10,
      DDCB_MODE_RESERVED = 2'b11
   } ddcb_mode_e;

   typedef logic [1:0] ddcb_preset_t;

endpackage

/* ddcb_field_reg.sv */
// Purpose: One software register with per-byte write enables
// Assumes: Write strobe already qualified by the bus handshake
// Notes: Width is a whole number of bytes
`timescale 1ns/1ps
`include "ddcb_cfg.svh"

module ddcb_field_reg import ddcb_pkg::*; #(
   parameter int W = 8,
   parameter logic [W-1:0] RST = '0
) (
   input wire logic clk_sys_i,
   input wire logic srst_i,
   input wire logic we_i,
   input wire logic [W/8-1:0] be_i,
   input wire logic [W-1:0] wdata_i,
   output logic [W-1:0] q_o
);

   genvar g;
   generate
      for (g = 0; g < W/8; g++) begin : g_lane
         always_ff @(posedge clk_sys_i) begin
            if (srst_i) begin
               q_o[g*8 +: 8] <= RST[g*8 +: 8];
            end else if (we_i && be_i[g]) begin
               q_o[g*8 +: 8] <= wdata_i[g*8 +: 8];
            end
         end
      end
   endgenerate

endmodule

/* tb_top.sv */
// Purpose: Self-checking bench for the preset select, binding and divisor bank
// Assumes: Avalon answers after a wait; outputs follow registers within two edges
// Notes: Each scenario is its own task; settle waits three rising edges and then a falling edge before looking
`timescale 1ns/1ps
`include "ddcb_cfg.svh"

module tb_top;
   logic clk_sys_i = 1'b0;
   logic srst_i = 1'b1;
   logic [11:0] avs_address_i = '0;
   logic avs_read_i = 1'b0;
   logic avs_write_i = 1'b0;
   logic [3:0] avs_byteenable_i = '0;
   logic [31:0] avs_writedata_i = '0;
   logic [31:0] avs_readdata_o;
   logic avs_waitrequest_o;
   logic [1:0] preset_pins_a_i = '0;
   logic [1:0] preset_pins_b_i = '0;
   logic [11:0] conv_a_data_i = 12'h5a3;
   logic [11:0] conv_b_data_i = 12'ha5c;
   logic [1:0] active_preset_a_o, active_preset_b_o;
   logic [15:0] ref_divisor_o;
   logic ref_divisor_en_o, dig_chan_a_pd_o, dig_chan_b_pd_o;
   logic [11:0] dig_chan_a_data_o, dig_chan_b_data_o;
   logic [31:0] rdat;
   int fails = 0;
   int n_compared = 0;
   int cycles = 0;

   ddcb_bank #(.DW(12)) ddcb_bank_inst (.clk_sys_i(clk_sys_i), .srst_i(srst_i),
      .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
      .avs_byteenable_i(avs_byteenable_i), .avs_writedata_i(avs_writedata_i),
      .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
      .preset_pins_a_i(preset_pins_a_i), .preset_pins_b_i(preset_pins_b_i),
      .conv_a_data_i(conv_a_data_i), .conv_b_data_i(conv_b_data_i),
      .active_preset_a_o(active_preset_a_o), .active_preset_b_o(active_preset_b_o),
      .ref_divisor_o(ref_divisor_o), .ref_divisor_en_o(ref_divisor_en_o),
      .dig_chan_a_pd_o(dig_chan_a_pd_o), .dig_chan_b_pd_o(dig_chan_b_pd_o),
      .dig_chan_a_data_o(dig_chan_a_data_o), .dig_chan_b_data_o(dig_chan_b_data_o));

   always #2.5 clk_sys_i = ~clk_sys_i;

   task end_sim;
      $display("Comparisons %0d, mismatches %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   always @(posedge clk_sys_i) begin
      cycles++;
      if (cycles == 20000) begin
         fails++;
         end_sim;
      end
   end

   task chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      n_compared++;
      if (got !== exp) begin
         fails++;
         $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask

   // One Avalon access; request held until waitrequest is seen low at an edge
   task bus(input logic wr, input logic [9:0] idx, input logic [31:0] d,
            input logic [3:0] be);
      int nw;
      nw = 0;
      @(posedge clk_sys_i);
      avs_address_i <= {idx, 2'b00};
      avs_read_i <= ~wr;
      avs_write_i <= wr;
      avs_writedata_i <= d;
      avs_byteenable_i <= be;
      // Waitrequest and read data are sampled at the rising edge that ends each cycle
      do begin
         @(posedge clk_sys_i);
         nw++;
      end while (avs_waitrequest_o !== 1'b0);
      rdat = avs_readdata_o;
      avs_read_i <= 1'b0;
      avs_write_i <= 1'b0;
      chk(nw, 32'h2, "edges until answer");
   endtask

   task settle;
      repeat (3) @(posedge clk_sys_i);
      @(negedge clk_sys_i);
   endtask

   task s_reset;
      settle;
      bus(0, `DDCB_IDX_PRESET_SELECT, 0, 4'hf);
      chk(rdat, 32'h0, "preset_select");
      bus(0, `DDCB_IDX_CHANNEL_BINDING, 0, 4'hf);
      chk(rdat, 32'h2, "binding");
      bus(0, `DDCB_IDX_REF_DIVISOR, 0, 4'hf);
      chk(rdat, 32'h0, "divisor");
      bus(0, `DDCB_IDX_MODE, 0, 4'hf);
      chk(rdat, 32'h0, "mode");
      settle;
      chk(ref_divisor_en_o, 1'b0, "divisor enable");
      chk({dig_chan_a_data_o, dig_chan_b_data_o}, {12'h5a3, 12'ha5c}, "reset route");
   endtask

   task s_presets;
      logic [1:0] ea, eb, pa, pb;
      for (int m = 0; m < 4; m++) begin
         for (int n = 0; n < 4; n++) begin
            pa = 2'(n + 1);
            pb = 2'(n + 2);
            @(posedge clk_sys_i);
            preset_pins_a_i <= pa;
            preset_pins_b_i <= pb;
            bus(1, `DDCB_IDX_MODE, 32'(m), 4'h1);
            bus(1, `DDCB_IDX_PRESET_SELECT, {28'h0, 2'(3 - n), 2'(n)}, 4'h1);
            ea = (m == 1 || m == 2) ? pa : 2'(n);
            eb = (m == 1) ? pb : (m == 2) ? pa : 2'(3 - n);
            settle;
            chk(active_preset_a_o, ea, "preset a");
            chk(active_preset_b_o, eb, "preset b");
         end
      end
   endtask

   task s_single;
      bus(1, `DDCB_IDX_MODE, 32'h0, 4'h1);
      bus(0, `DDCB_IDX_CHANNEL_BINDING, 0, 4'hf);
      chk(rdat, 32'h2, "binding before single mode");
      bus(1, `DDCB_IDX_CTRL, 32'h1, 4'h1);
      bus(1, `DDCB_IDX_PRESET_SELECT, 32'h0d, 4'h1);
      settle;
      chk(active_preset_a_o, 2'h1, "single preset a");
      chk(active_preset_b_o, 2'h1, "single preset b");
      bus(0, `DDCB_IDX_STATUS, 0, 4'hf);
      chk(rdat, 32'h5, "status presets");
      bus(1, `DDCB_IDX_CTRL, 32'h0, 4'h1);
   endtask

   task s_bind;
      logic pa, pb;
      for (int b = 0; b < 4; b++) begin
         for (int p = 0; p < 4; p++) begin
            bus(1, `DDCB_IDX_CHANNEL_BINDING, 32'(b), 4'h1);
            bus(1, `DDCB_IDX_CTRL, 32'(p << 1), 4'h1);
            pa = b[0] ? p[1] : p[0];
            pb = b[1] ? p[1] : p[0];
            settle;
            chk({dig_chan_a_pd_o, dig_chan_b_pd_o}, {pa, pb}, "power-down");
            chk(dig_chan_a_data_o, pa ? 12'h0 : (b[0] ? 12'ha5c : 12'h5a3), "chan a");
            chk(dig_chan_b_data_o, pb ? 12'h0 : (b[1] ? 12'ha5c : 12'h5a3), "chan b");
         end
      end
      bus(1, `DDCB_IDX_CTRL, 32'h0, 4'h1);
      bus(1, `DDCB_IDX_CHANNEL_BINDING, 32'h2, 4'h1);
   endtask

   task s_div;
      bus(1, `DDCB_IDX_REF_DIVISOR, 32'h1f00, 4'h3);
      bus(1, `DDCB_IDX_REF_DIVISOR, 32'hff, 4'h1);
      settle;
      chk({ref_divisor_en_o, ref_divisor_o}, {1'b1, 16'h1fff}, "divisor on");
      bus(0, `DDCB_IDX_REF_DIVISOR, 0, 4'hf);
      chk(rdat, 32'h1fff, "divisor read");
      bus(1, `DDCB_IDX_PRESET_SELECT, 32'h0e, 4'h1);
      settle;
      chk(ref_divisor_o, 16'h1fff, "divisor shared");
      bus(1, `DDCB_IDX_REF_DIVISOR, 32'h0, 4'h3);
      settle;
      chk({ref_divisor_en_o, ref_divisor_o}, 17'h0, "divisor off");
      bus(1, 10'h100, 32'hff, 4'hf);
      bus(0, 10'h100, 0, 4'hf);
      chk(rdat, 32'h0, "unmapped");
   endtask

   // Mid-run reset restores registers and outputs
   task s_rerun;
      bus(1, `DDCB_IDX_PRESET_SELECT, 32'h0b, 4'h1);
      bus(1, `DDCB_IDX_REF_DIVISOR, 32'h1234, 4'h3);
      srst_i <= 1'b1;
      repeat (3) @(posedge clk_sys_i);
      srst_i <= 1'b0;
      settle;
      chk({active_preset_a_o, active_preset_b_o}, 4'h0, "presets after reset");
      chk({ref_divisor_en_o, ref_divisor_o}, 17'h0, "divisor out after reset");
      bus(0, `DDCB_IDX_PRESET_SELECT, 0, 4'hf);
      chk(rdat, 32'h0, "preset_select after reset");
      bus(0, `DDCB_IDX_REF_DIVISOR, 0, 4'hf);
      chk(rdat, 32'h0, "divisor after reset");
   endtask

   initial begin
      repeat (3) @(posedge clk_sys_i);
      srst_i <= 1'b0;
      s_reset;
      s_presets;
      s_single;
      s_bind;
      s_div;
      s_rerun;
      end_sim;
   end
endmodule
